/* File: core/sms_pkg.sv */
// Shared constants and types of the switch mode supervisor.
package sms_pkg;

    // Clock rate of the supervisor's own oscillator clock.
    localparam int unsigned CLK_MHZ = 125;

    // Watchdog timeout and input idle time, in milliseconds.
    localparam int unsigned WD_TIMEOUT_MS = 310;
    localparam int unsigned IN_IDLE_MS    = 250;

    // Derived cycle counts; a longest time rounds down, which is exact here.
    localparam int unsigned WD_TIMEOUT_CYC = WD_TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int unsigned IN_IDLE_CYC    = IN_IDLE_MS * 1000 * CLK_MHZ;

    // Timer width, wide enough for both counts.
    localparam int unsigned TMR_W = 26;

    // Serial word layout: 16 bits, toggle bit in the first (top) bit.
    localparam int unsigned WORD_W    = 16;
    localparam int unsigned WD_BIT    = 15;
    localparam int unsigned BITCNT_W  = 4;

    // Bit positions of the fault-source detection enables.
    localparam int unsigned DET_STB    = 0;
    localparam int unsigned DET_OL_OFF = 1;
    localparam int unsigned DET_OL_ON  = 2;
    localparam int unsigned DET_CLK    = 3;
    localparam int unsigned DET_OV     = 4;
    localparam int unsigned DET_W      = 5;

    // Reset value: clock failure and over-voltage on, the rest off.
    localparam logic [4:0] DET_RESET = 5'h18;

    // Operating modes.
    typedef enum logic [1:0] {
        SMS_SLEEP,
        SMS_NORMAL,
        SMS_FAILSAFE,
        SMS_FAULT
    } sms_mode_t;

    // Per-channel fault causes, also the layout of each channel fault register.
    typedef struct packed {
        logic oc;      // Over-current.
        logic ot;      // Over-temperature.
        logic sc;      // Severe short-circuit.
        logic stb;     // Off-state short to supply.
        logic ol_off;  // Open load in off state.
        logic ol_on;   // Open load in on state.
    } sms_chan_fault_t;

    // Global fault causes, also the layout of the status register.
    typedef struct packed {
        logic uv;        // Under-voltage.
        logic ov;        // Over-voltage.
        logic clk_fail;  // External clock failure.
    } sms_glob_fault_t;

    // Per-channel control settings from the channel registers.
    typedef struct packed {
        logic on_bit;         // Channel on request.
        logic pwm_enable;     // Duty-cycle modulation on.
        logic dir_in_disable; // Direct input ignored.
        logic duty_phase;     // Current phase of the 8-bit duty generator.
    } sms_chan_ctrl_t;

endpackage : sms_pkg

/* File: core/sms_supervisor.sv */
// Operating-mode supervisor for a dual-channel high-side switch.
// Summary of operation
// - Target drive is direct input unless disabled, or on bit gated by PWM phase.
// - Wake edge with both supplies, or input edge with main supply, enters Normal.
// - Watchdog starts on wake edge; first word bit must alternate within 310 ms.
// - Activity flag clears after a direct input stays idle over 250 ms.
// - Sleep when wake pin and both activity flags are low; wake-up is their OR.
// - Wake pin low or Fail-safe: channels follow only direct inputs, protections stay.
// - Fault term: channel OC, OT, SC, or under-voltage, or enabled over-voltage.
// - Mode decode: Sleep, Normal, Fail-safe and Fault from wake, fail-safe, fault.
// - Watchdog runs only with logic supply, watchdog enabled and wake pin high.
// - Fail-safe on timeout or enabled logic-supply loss; disable blocks timeout.
// - Fail-safe entry drives output low, delatches, resets registers, blocks access.
// - Back to Normal: release output, reset faults and registers but latched bits.
// - Power-up in Sleep; registers held at defaults, channels and serial port off.
// - Detection enables reset with clock fail and over-voltage on, others off.
// - Fault status pin follows faults live; fault bits stay set until read.
// - Faults turn off their channel except OL, clock fail, STB; UV and enabled OV turn off both.
// - Reading clears a fault bit only when the cause is gone and, for OC, OT, SC and UV, not latched.
`timescale 1ns/100ps
module sms_supervisor #(
    parameter int unsigned WD_CYCLES   = sms_pkg::WD_TIMEOUT_CYC, // Watchdog timeout.
    parameter int unsigned IDLE_CYCLES = sms_pkg::IN_IDLE_CYC     // Input idle time.
) (
    input  wire logic                   clk,               // Oscillator clock.
    input  wire logic                   rst,               // Power-on reset.
    input  wire logic                   spi_clk,           // Serial link clock.
    input  wire logic                   spi_cs_n,          // Serial frame select.
    input  wire logic                   spi_mosi,          // Serial data in.
    input  wire logic                   wake_request_pin,  // Wake request pin.
    input  wire logic [1:0]             direct_in,         // Direct input pins.
    input  wire logic                   main_supply_ok,    // Main supply present.
    input  wire logic                   logic_supply_ok,   // Logic supply present.
    input  wire logic                   watchdog_disable,  // Watchdog disable bit.
    input  wire logic                   logic_supply_loss_enable, // Supply-loss enable.
    input  wire sms_pkg::sms_chan_ctrl_t ctrl [2],         // Channel settings.
    input  wire sms_pkg::sms_chan_fault_t chan_fault [2],  // Live channel faults.
    input  wire sms_pkg::sms_glob_fault_t glob_fault,      // Live global faults.
    input  wire logic [1:0]             latched,           // Channel latched.
    input  wire logic                   det_wr,            // Detection enable write.
    input  wire logic [4:0]             det_wdata,         // Detection enable data.
    input  wire logic                   status_read,       // Status register read.
    input  wire logic [1:0]             fault_read,        // Fault register reads.
    output sms_pkg::sms_mode_t          mode,              // Operating mode.
    output logic                        normal_mode_flag,  // Normal mode.
    output logic [1:0]                  hson,              // Channel target drive.
    output logic [1:0]                  input_activity,    // Activity flags.
    output logic                        failsafe_out_n_o,  // Fail-safe pin level.
    output logic                        failsafe_out_n_oe, // Fail-safe pin enable.
    output logic                        fault_status_n,    // Live fault status.
    output sms_pkg::sms_chan_fault_t    channel_fault_reg [2], // Sticky channel bits.
    output sms_pkg::sms_glob_fault_t    channel_status_reg,    // Sticky global bits.
    output logic [4:0]                  detect_enable,     // Detection enables.
    output logic                        reg_clear,         // Register reset.
    output logic                        reg_access_block,  // Register access blocked.
    output logic                        delatch,           // Delatch pulse.
    output logic                        serial_enable,     // Serial port on.
    output logic                        word_write_ok,     // Word may write registers.
    output logic [15:0]                 word_data          // Received word.
);

    // Link domain: shift in bits; the counter is cleared by the frame select.
    logic [3:0]  bitcnt_r;
    logic [15:0] shift_r;
    logic [15:0] link_word_r;
    logic        link_tgl_r;

    always_ff @(posedge spi_clk or posedge spi_cs_n)
    begin
        if (spi_cs_n)
            bitcnt_r <= 4'h0;
        else
            bitcnt_r <= bitcnt_r + 4'h1;
    end

    // Shift register and word hand-off; the word stays stable until the next one.
    always_ff @(posedge spi_clk or posedge rst)
    begin
        if (rst)
        begin
            shift_r     <= 16'h0000;
            link_word_r <= 16'h0000;
            link_tgl_r  <= 1'b0;
        end
        else if (!spi_cs_n)
        begin
            shift_r <= {shift_r[14:0], spi_mosi};
            if (bitcnt_r == 4'hf)
            begin
                link_word_r <= {shift_r[14:0], spi_mosi};
                link_tgl_r  <= ~link_tgl_r;
            end
        end
    end

    // Two-flop synchronisers for pins and the word toggle.
    logic [5:0] meta_r;
    logic [5:0] sync_r;
    logic [5:0] prev_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_r <= 6'h00;
            sync_r <= 6'h00;
            prev_r <= 6'h00;
        end
        else
        begin
            meta_r <= {link_tgl_r, logic_supply_ok, main_supply_ok, direct_in,
                       wake_request_pin};
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    logic       wake_s;
    logic [1:0] in_s;
    logic [1:0] in_rise;
    logic       main_s;
    logic       logic_s;
    logic       wake_rise;
    logic       word_evt;

    assign wake_s    = sync_r[0];
    assign in_s      = sync_r[2:1];
    assign in_rise   = sync_r[2:1] & ~prev_r[2:1];
    assign main_s    = sync_r[3];
    assign logic_s   = sync_r[4];
    assign wake_rise = sync_r[0] & ~prev_r[0];
    assign word_evt  = sync_r[5] ^ prev_r[5];

    // Per-channel idle timers clear the activity flag after a quiet input.
    logic [1:0] act_r;

    for (genvar ch = 0; ch < 2; ch++)
    begin : g_idle
        logic [25:0] idle_cnt_r;

        always_ff @(posedge clk)
        begin
            if (rst || (sync_r[ch + 1] != prev_r[ch + 1]))
                idle_cnt_r <= 26'h0;
            else if ({6'h0, idle_cnt_r} < IDLE_CYCLES)
                idle_cnt_r <= idle_cnt_r + 26'h1;
        end

        always_ff @(posedge clk)
        begin
            if (rst)
                act_r[ch] <= 1'b0;
            else if (in_rise[ch] && main_s)
                act_r[ch] <= 1'b1;
            else if ({6'h0, idle_cnt_r} >= IDLE_CYCLES)
                act_r[ch] <= 1'b0;
        end
    end

    logic wake_term;
    assign wake_term = wake_s | act_r[0] | act_r[1];

    // Fault term and per-channel turn-off.
    logic [4:0] det_r;
    logic       ov_on;
    logic       fault_term;
    logic [1:0] kill;
    logic       any_fault;

    assign ov_on = glob_fault.ov & det_r[sms_pkg::DET_OV];
    assign fault_term = chan_fault[0].oc | chan_fault[0].ot | chan_fault[0].sc
                      | chan_fault[1].oc | chan_fault[1].ot | chan_fault[1].sc
                      | glob_fault.uv | ov_on;
    assign kill[0] = chan_fault[0].oc | chan_fault[0].ot | chan_fault[0].sc
                   | glob_fault.uv | ov_on;
    assign kill[1] = chan_fault[1].oc | chan_fault[1].ot | chan_fault[1].sc
                   | glob_fault.uv | ov_on;
    assign any_fault = fault_term
                     | (glob_fault.clk_fail & det_r[sms_pkg::DET_CLK])
                     | ((chan_fault[0].stb | chan_fault[1].stb) & det_r[sms_pkg::DET_STB])
                     | ((chan_fault[0].ol_off | chan_fault[1].ol_off)
                        & det_r[sms_pkg::DET_OL_OFF])
                     | ((chan_fault[0].ol_on | chan_fault[1].ol_on)
                        & det_r[sms_pkg::DET_OL_ON]);

    // Watchdog, fail-safe flag and the two-word exit sequence.
    sms_pkg::sms_mode_t mode_r;
    logic        fs_r;
    logic        wd_run_r;
    logic        armed_r;
    logic        last_tgl_r;
    logic [25:0] wd_cnt_r;
    logic        wd_active;
    logic        wd_expired;
    logic        supply_seen_r;
    logic        exit_word;

    assign wd_active  = wd_run_r && logic_s && !watchdog_disable && wake_s
                      && (mode_r == sms_pkg::SMS_NORMAL) && !fs_r;
    assign wd_expired = {6'h0, wd_cnt_r} >= WD_CYCLES;
    assign exit_word  = fs_r && armed_r && word_evt && !wd_expired && logic_s;

    // Timer restarts on each alternation of the toggle bit and on arming.
    always_ff @(posedge clk)
    begin
        if (rst || wake_rise || (word_evt && (sync_word_tgl() != last_tgl_r))
            || (fs_r && !armed_r))
            wd_cnt_r <= 26'h0;
        else if ((wd_active || armed_r) && !wd_expired)
            wd_cnt_r <= wd_cnt_r + 26'h1;
    end

    function automatic logic sync_word_tgl();
        return link_word_r[sms_pkg::WD_BIT];
    endfunction : sync_word_tgl

    // Watchdog start, toggle history and logic-supply presence history.
    always_ff @(posedge clk)
    begin
        if (rst || mode_r == sms_pkg::SMS_SLEEP && !wake_rise)
        begin
            wd_run_r      <= 1'b0;
            last_tgl_r    <= 1'b0;
            supply_seen_r <= 1'b0;
        end
        else
        begin
            if (wake_rise && logic_s)
                wd_run_r <= 1'b1;
            if (word_evt)
                last_tgl_r <= link_word_r[sms_pkg::WD_BIT];
            if (logic_s)
                supply_seen_r <= 1'b1;
        end
    end

    // Fail-safe flag: set wins over the exit sequence clearing it.
    always_ff @(posedge clk)
    begin
        if (rst || mode_r == sms_pkg::SMS_SLEEP)
        begin
            fs_r    <= 1'b0;
            armed_r <= 1'b0;
        end
        else if ((wd_active && wd_expired)
                 || (supply_seen_r && !logic_s && logic_supply_loss_enable))
        begin
            fs_r    <= 1'b1;
            armed_r <= 1'b0;
        end
        else if (exit_word)
        begin
            fs_r    <= 1'b0;
            armed_r <= 1'b0;
        end
        else if (fs_r && word_evt && link_word_r[sms_pkg::WD_BIT])
            armed_r <= 1'b1;
        else if (armed_r && wd_expired)
            armed_r <= 1'b0;
    end

    // Mode decode; leaving Sleep needs a wake or input edge.
    always_ff @(posedge clk)
    begin
        if (rst)
            mode_r <= sms_pkg::SMS_SLEEP;
        else
        begin
            case (mode_r)
                sms_pkg::SMS_SLEEP:
                begin
                    if ((wake_rise && main_s && logic_s) || (|in_rise && main_s))
                        mode_r <= sms_pkg::SMS_NORMAL;
                end
                default:
                begin
                    if (!wake_term)
                        mode_r <= sms_pkg::SMS_SLEEP;
                    else if (fault_term)
                        mode_r <= sms_pkg::SMS_FAULT;
                    else if (fs_r)
                        mode_r <= sms_pkg::SMS_FAILSAFE;
                    else
                        mode_r <= sms_pkg::SMS_NORMAL;
                end
            endcase
        end
    end

    // Edge detect on the fail-safe flag for entry and return actions.
    logic fs_d_r;
    logic fs_enter;
    logic fs_leave;

    always_ff @(posedge clk)
    begin
        if (rst)
            fs_d_r <= 1'b0;
        else
            fs_d_r <= fs_r;
    end

    assign fs_enter = fs_r & ~fs_d_r;
    assign fs_leave = ~fs_r & fs_d_r;

    // Register reset, access block, delatch and word forwarding.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            reg_clear        <= 1'b1;
            reg_access_block <= 1'b0;
            delatch          <= 1'b0;
            word_write_ok    <= 1'b0;
            word_data        <= 16'h0000;
        end
        else
        begin
            reg_clear        <= (mode_r == sms_pkg::SMS_SLEEP) || fs_enter || fs_leave
                              || (fs_r && !exit_word);
            reg_access_block <= fs_r && !exit_word;
            delatch          <= fs_enter;
            word_write_ok    <= word_evt && ((!fs_r && mode_r != sms_pkg::SMS_SLEEP && logic_s)
                                           || exit_word);
            if (word_evt)
                word_data <= link_word_r;
        end
    end

    // Detection enables: defaults after reset and whenever registers reset.
    always_ff @(posedge clk)
    begin
        if (rst || reg_clear)
            det_r <= sms_pkg::DET_RESET;
        else if (det_wr && !fs_r && mode_r != sms_pkg::SMS_SLEEP)
            det_r <= det_wdata;
    end

    // Sticky fault bits; a new cause wins over a read.
    sms_pkg::sms_chan_fault_t cf_r [2];
    sms_pkg::sms_glob_fault_t gf_r;

    for (genvar ch = 0; ch < 2; ch++)
    begin : g_fault
        sms_pkg::sms_chan_fault_t live;
        sms_pkg::sms_chan_fault_t keep;

        assign live = chan_fault[ch];
        assign keep = latched[ch] ? 6'h38 : 6'h00;

        always_ff @(posedge clk)
        begin
            if (rst)
                cf_r[ch] <= '0;
            else if (fs_leave)
                cf_r[ch] <= (cf_r[ch] & keep) | live;
            else if (fault_read[ch])
                cf_r[ch] <= live | (cf_r[ch] & keep);
            else
                cf_r[ch] <= cf_r[ch] | live;
        end
    end

    // Global bits: under-voltage stays while either channel is latched.
    sms_pkg::sms_glob_fault_t g_keep;
    assign g_keep = (|latched) ? 3'h4 : 3'h0;

    always_ff @(posedge clk)
    begin
        if (rst)
            gf_r <= '0;
        else if (fs_leave)
            gf_r <= (gf_r & g_keep) | glob_fault;
        else if (status_read)
            gf_r <= glob_fault | (gf_r & g_keep);
        else
            gf_r <= gf_r | glob_fault;
    end

    // Channel drive; direct-input only when wake is low or in Fail-safe.
    logic [1:0] hson_r;
    logic       direct_only;
    assign direct_only = !wake_s || fs_r;

    always_ff @(posedge clk)
    begin
        if (rst)
            hson_r <= 2'b00;
        else
        begin
            for (int ch = 0; ch < 2; ch++)
            begin
                if (mode_r == sms_pkg::SMS_SLEEP)
                    hson_r[ch] <= 1'b0;
                else if (direct_only)
                    hson_r[ch] <= in_s[ch] && !kill[ch];
                else
                    hson_r[ch] <= ((in_s[ch] && !ctrl[ch].dir_in_disable)
                                  || (ctrl[ch].on_bit && ctrl[ch].duty_phase
                                      && ctrl[ch].pwm_enable)
                                  || (ctrl[ch].on_bit && !ctrl[ch].pwm_enable))
                                  && !kill[ch];
            end
        end
    end

    // Live fault pin is a registered copy so it settles cleanly.
    always_ff @(posedge clk)
    begin
        if (rst)
            fault_status_n <= 1'b1;
        else
            fault_status_n <= !any_fault;
    end

    assign mode                = mode_r;
    assign normal_mode_flag    = (mode_r == sms_pkg::SMS_NORMAL);
    assign hson                = hson_r;
    assign input_activity      = act_r;
    assign failsafe_out_n_o    = 1'b0;
    assign failsafe_out_n_oe   = fs_r;
    assign channel_fault_reg   = cf_r;
    assign channel_status_reg  = gf_r;
    assign detect_enable       = det_r;
    assign serial_enable       = (mode_r != sms_pkg::SMS_SLEEP);

endmodule : sms_supervisor

/* File: dv/sms_host.sv */
// Host model that sends 16-bit words on the serial link.
`timescale 1ns/100ps
module sms_host (
    output logic spi_clk,  // Link clock.
    output logic spi_cs_n, // Frame select.
    output logic spi_mosi  // Data out.
);
    // The link clock stands still between frames.
    initial
    begin
        spi_clk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // Top bit first; idle data shows the inverse so stale bits never look valid.
    task automatic send(input logic [15:0] w);
        #3.7 spi_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            spi_mosi = w[i];
            #32 spi_clk = 1'b1;
            #32 spi_clk = 1'b0;
        end
        #16 spi_cs_n = 1'b1;
        spi_mosi = ~w[0];
    endtask : send
endmodule : sms_host

/* File: dv/sms_supervisor_tb.sv */
// Self-checking bench for the switch mode supervisor.
`timescale 1ns/100ps
module sms_supervisor_tb;
    localparam int WD = 400;   // Short watchdog timeout.
    localparam int IDLE = 150; // Short idle time.
    logic                     clk, rst, spi_clk, spi_cs_n, spi_mosi, det_wr, status_read;
    logic                     wake_request_pin, main_supply_ok, logic_supply_ok;
    logic                     watchdog_disable, logic_supply_loss_enable, delatch;
    logic                     normal_mode_flag, failsafe_out_n_o, failsafe_out_n_oe;
    logic                     fault_status_n, reg_clear, reg_access_block;
    logic                     serial_enable, word_write_ok;
    logic [1:0]               direct_in, latched, fault_read, hson, input_activity;
    logic [4:0]               det_wdata, detect_enable;
    logic [7:0]               rnd;
    logic [15:0]              word_data;
    logic [15:0]              exp_q [$];
    sms_pkg::sms_chan_ctrl_t  ctrl [2];
    sms_pkg::sms_chan_fault_t chan_fault [2], channel_fault_reg [2];
    sms_pkg::sms_glob_fault_t glob_fault, channel_status_reg;
    sms_pkg::sms_mode_t       mode;
    int                       num_errors, cmp_count;

    sms_supervisor #(.WD_CYCLES(WD), .IDLE_CYCLES(IDLE)) dut (.*);
    sms_host host (.spi_clk, .spi_cs_n, .spi_mosi);

    // Shift register for random values, and the expected drive of one channel.
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    function automatic logic drive(input logic d, input sms_pkg::sms_chan_ctrl_t c);
        return (d & ~c.dir_in_disable) | (c.on_bit & (c.duty_phase | ~c.pwm_enable));
    endfunction : drive
    // Compares and counts; an unknown passes only where the expected value has the same unknown bit.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check
    // Bounded wait for a mode, sampled at the falling edge where it is settled.
    task automatic wait_mode(input sms_pkg::sms_mode_t m, input int n);
        for (int i = 0; i < n && mode !== m; i++)
            @(negedge clk);
        check(mode, m);
        check(normal_mode_flag, m == sms_pkg::SMS_NORMAL);
    endtask : wait_mode
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    // Clock, and a watchdog well beyond the expected run of about 1000 cycles.
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
    // Each written word is matched to the oldest expected word.
    always @(negedge clk)
        if (word_write_ok === 1'b1)
            check(word_data, exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx);

    // Main sequence.
    initial
    begin
        rst = 1'b1;
        {wake_request_pin, det_wr, status_read, logic_supply_loss_enable} = '0;
        {main_supply_ok, logic_supply_ok, watchdog_disable} = 3'h7;
        {direct_in, latched, fault_read, det_wdata} = '0;
        ctrl = '{default: '0};
        chan_fault = '{default: '0};
        glob_fault = '0;
        {num_errors, cmp_count} = '0;
        rnd = 8'h5a;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check(mode, sms_pkg::SMS_SLEEP);
        check(detect_enable, sms_pkg::DET_RESET);
        check({hson, input_activity, fault_status_n, failsafe_out_n_oe, serial_enable,
               reg_clear}, 8'h09);
        $display("reset test done");
        @(posedge clk);
        direct_in <= 2'h1;
        wait_mode(sms_pkg::SMS_NORMAL, 10);
        @(posedge clk);
        wake_request_pin <= 1'b1;
        repeat (16)
        begin
            rnd = lfsr(rnd);
            @(posedge clk);
            ctrl[0] <= rnd[3:0];
            ctrl[1] <= rnd[7:4];
            repeat (4) @(negedge clk);
            check(hson, {drive(1'b0, ctrl[1]), drive(1'b1, ctrl[0])});
        end
        $display("drive test done");
        // Both channels on by bit; a read clears only an unlatched bit.
        for (int l = 1; l >= 0; l--)
        begin
            @(posedge clk);
            ctrl <= '{default: 4'ha};
            chan_fault[0].oc <= 1'b1;
            wait_mode(sms_pkg::SMS_FAULT, 8);
            repeat (2) @(negedge clk);
            check({fault_status_n, hson}, 3'h2);
            @(posedge clk);
            chan_fault[0].oc <= 1'b0;
            latched[0] <= l[0];
            wait_mode(sms_pkg::SMS_NORMAL, 8);
            check(channel_fault_reg[0].oc, 1'b1);
            @(posedge clk);
            fault_read[0] <= 1'b1;
            @(posedge clk);
            fault_read[0] <= 1'b0;
            repeat (2) @(negedge clk);
            check(channel_fault_reg[0].oc, l[0]);
        end
        @(posedge clk);
        glob_fault.ov <= 1'b1;
        wait_mode(sms_pkg::SMS_FAULT, 8);
        repeat (2) @(negedge clk);
        check(hson, 2'h0);
        @(posedge clk);
        glob_fault.ov <= 1'b0;
        wait_mode(sms_pkg::SMS_NORMAL, 8);
        check(channel_status_reg, 3'h2);
        $display("fault test done");
        @(posedge clk);
        watchdog_disable <= 1'b0;
        wait_mode(sms_pkg::SMS_FAILSAFE, WD + 50);
        repeat (2) @(negedge clk);
        check({failsafe_out_n_oe, failsafe_out_n_o, reg_access_block, hson},
              5'h15);
        rnd = lfsr(rnd);
        host.send({8'h80, rnd});
        repeat (8) @(posedge clk);
        exp_q.push_back({rnd, 8'h3c});
        host.send({rnd, 8'h3c});
        wait_mode(sms_pkg::SMS_NORMAL, 20);
        check(failsafe_out_n_oe, 1'b0);
        @(posedge clk);
        watchdog_disable <= 1'b1;
        $display("watchdog test done");
        @(posedge clk);
        wake_request_pin <= 1'b0;
        direct_in <= 2'h0;
        wait_mode(sms_pkg::SMS_SLEEP, IDLE + 50);
        repeat (2) @(negedge clk);
        check({hson, input_activity}, 4'h0);
        @(posedge clk);
        wake_request_pin <= 1'b1;
        wait_mode(sms_pkg::SMS_NORMAL, 10);
        check(exp_q.size(), 0);
        $display("sleep test done");
        print_verdict();
    end
endmodule : sms_supervisor_tb

/* File: dv/sms_sva.sv */
// Port assertions for the switch mode supervisor.
`timescale 1ns/100ps
module sms_sva (
    input logic                     clk,               // Clock.
    input logic                     rst,               // Reset.
    input logic                     wake_request_pin,  // Wake pin.
    input sms_pkg::sms_chan_fault_t chan_fault [2],    // Live faults.
    input sms_pkg::sms_glob_fault_t glob_fault,        // Global faults.
    input logic [1:0]               latched,           // Latched.
    input logic [1:0]               fault_read,        // Reads.
    input sms_pkg::sms_mode_t       mode,              // Mode.
    input logic [1:0]               hson,              // Drive.
    input logic                     failsafe_out_n_oe, // Fail-safe.
    input logic                     fault_status_n,    // Fault pin.
    input sms_pkg::sms_chan_fault_t channel_fault_reg [2], // Sticky.
    input logic                     reg_clear,         // Clear.
    input logic                     delatch            // Delatch.
);
    // One clock domain; a register reset window may clear sticky bits.
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (rst);
    sleep_off_a: assert property (
        (mode == sms_pkg::SMS_SLEEP) [*2] |-> hson == 2'h0) else $error("sleep drive");
    wake_normal_a: assert property (
        mode == sms_pkg::SMS_SLEEP && $rose(wake_request_pin)
        |-> ##[1:6] mode == sms_pkg::SMS_NORMAL) else $error("no wake");
    fault_live_a: assert property (
        chan_fault[0].oc || chan_fault[1].oc || glob_fault.uv |=> !fault_status_n)
        else $error("fault pin high");
    sticky_hold_a: assert property (
        channel_fault_reg[0].oc && !fault_read[0] && !reg_clear ##1 !reg_clear
        |-> channel_fault_reg[0].oc) else $error("sticky lost");
    read_clear_a: assert property (
        fault_read[0] && !chan_fault[0].oc && !latched[0] |=> !channel_fault_reg[0].oc)
        else $error("bit kept");
    latch_keep_a: assert property (
        fault_read[0] && latched[0] && channel_fault_reg[0].oc && !reg_clear
        |=> channel_fault_reg[0].oc) else $error("latched bit cleared");
    fs_pin_a: assert property (
        $rose(mode == sms_pkg::SMS_FAILSAFE) |-> failsafe_out_n_oe) else $error("pin high");
    fs_delatch_a: assert property (
        $rose(failsafe_out_n_oe) |-> ##[0:1] delatch) else $error("no delatch");
endmodule : sms_sva

bind sms_supervisor sms_sva u_sva (.clk, .rst, .wake_request_pin, .chan_fault,
    .glob_fault, .latched, .fault_read, .mode, .hson, .failsafe_out_n_oe,
    .fault_status_n, .channel_fault_reg, .reg_clear, .delatch);
